// File: src/rtc_defs.svh
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// register byte addresses
`define RTC_ADDR_XFAIL 32'h00130080
`define RTC_ADDR_CTRL 32'hFFF7E400
`define RTC_ADDR_COUNT 32'hFFF7E404
`define RTC_ADDR_PRESET 32'hFFF7E408
`define RTC_ADDR_INTEN 32'hFFF7E40C
`define RTC_ADDR_FLAGS 32'hFFF7E410
`define RTC_ADDR_PRESCALE 32'hFFF7E414

// time word fields
`define RTC_DAYS_MSB 27
`define RTC_DAYS_LSB 17
`define RTC_HOURS_MSB 16
`define RTC_HOURS_LSB 12
`define RTC_MINS_MSB 11
`define RTC_MINS_LSB 6
`define RTC_SECS_MSB 5
`define RTC_SECS_LSB 0
`define RTC_SECS_LAST 6'h3B
`define RTC_MINS_LAST 6'h3B
`define RTC_HOURS_LAST 5'h17

// control word fields and resets
`define RTC_CTRL_PRESET_BIT 0
`define RTC_CTRL_MODE_LSB 2
`define RTC_CTRL_INLOAD_LSB 4
`define RTC_CTRL_OUTLOAD_LSB 10
`define RTC_CTRL_BIAS_LSB 15
`define RTC_MODE_RST 2'h3
`define RTC_MODE_OFF 2'h3
`define RTC_LOAD_RST 5'h0F
`define RTC_LOAD_MAX 5'h14
`define RTC_BIAS_RST 3'h4
`define RTC_BIAS_MIN 3'h4

// prescaler
`define RTC_PRESCALE_RST 10'h2CF
`define RTC_PRESCALE_STEP 8
`define RTC_ONE_SEC_BASE 10000000

// crystal fail detect word
`define RTC_XF_MON_BIT 0
`define RTC_XF_IRQ_BIT 1
`define RTC_XF_LOWER_LSB 2
`define RTC_XF_UPPER_LSB 7
`define RTC_XF_UPPER_RST 5'h10
`define RTC_XF_LOWER_RST 5'h0A
`define RTC_XF_LAST_PERIOD 2'h2
`define RTC_MCNT_MAX 6'h3F

// interval flag bits, bit 4 is crystal fail
`define RTC_FLAG_FAIL 4
`define RTC_FLAG_MIN 3
`define RTC_TEN 6'h0A
`define RTC_THIRTY 6'h1E

`endif

// File: src/rtc_pkg.sv
package rtc_pkg;
  typedef enum logic [1:0] {
    RTC_FD_IDLE = 2'b00,
    RTC_FD_ARM = 2'b01,
    RTC_FD_RUN = 2'b10
  } rtc_fd_state_e;
  typedef logic [27:0] rtc_time_t;
endpackage

// File: src/rtc_top.sv
// Overview of operation
// - time count word reads days, hours, minutes, seconds; cleared at reset.
// - preset word uses the same field layout, all fields reset to zero.
// - control bit 0 enables loading the time count from the preset word.
// - four interval interrupt enables for 60, 30, 10 and 1 seconds.
// - four interval flags for 60, 30, 10 and 1 seconds, cleared at reset.
// - 10-bit prescaler resets to 0x2CF, the nominal one-second count.
// - each prescaler step from nominal moves the rollover by eight reference periods.
// - crystal-side counter clears the main-clock counter every three crystal periods.
// - at each clear after the first one the main-clock count is checked against a 5-bit upper limit.
// - at each clear after the first one the main-clock count is checked against a 5-bit lower limit.
// - monitor enable bit turns crystal failure detection on; off at reset.
// - crystal fail interrupt enable gates the failure interrupt; off at reset.
// - input mode selects crystal, external clock, or disabled (reset value).
// - two load codes reset to 0x0F, 2 pF per step, above 20 gives maximum.
// - bias select resets to 4; codes 4 to 7 all mean the smallest resistor.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_top
  import rtc_pkg::*;
#(
  parameter int ONE_SEC_BASE = `RTC_ONE_SEC_BASE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_input_pin,
  output logic irq,
  output logic [1:0] oscillator_input_mode,
  output logic [4:0] input_pin_load_code,
  output logic [4:0] output_pin_load_code,
  output logic [2:0] bias_select
);

  logic rst_meta_reg, rst_sync_n;
  logic pready_reg, pslverr_reg, irq_reg;
  logic [31:0] prdata_reg;
  logic ctrl_preset_en_reg;
  logic [1:0] osc_mode_reg, mode_out_reg;
  logic [4:0] in_load_reg, out_load_reg, in_load_out_reg, out_load_out_reg;
  logic [2:0] bias_reg, bias_out_reg;
  rtc_time_t count_reg, preset_reg, count_next;
  logic [3:0] int_en_reg, int_en_next;
  logic [4:0] flags_reg, flags_next, flag_set, flag_clr;
  logic [9:0] prescale_reg;
  logic [31:0] presc_cnt_reg, rollover, rd_data;
  logic [4:0] xf_upper_reg, xf_lower_reg;
  logic xf_irq_en_reg, xf_irq_en_next, xf_mon_en_reg, ref_d_reg;
  logic [1:0] xcnt_reg;
  logic [5:0] mcnt_reg, new_secs;
  rtc_fd_state_e fd_state_reg;
  logic wr_en, rd_hit, ref_edge, tick, fd_clear, fail_event;

  // rollover count in reference periods, trimmed by the prescaler
  function automatic logic [31:0] sec_rollover(input logic [9:0] ps);
    logic signed [31:0] delta;
    delta = $signed({22'h0, ps}) - $signed({22'h0, `RTC_PRESCALE_RST});
    sec_rollover = 32'(ONE_SEC_BASE + delta * `RTC_PRESCALE_STEP);
  endfunction

  // advance a packed time word by one second
  function automatic rtc_time_t next_time(input rtc_time_t t);
    rtc_time_t n;
    n = t;
    if (t[`RTC_SECS_MSB:`RTC_SECS_LSB] != `RTC_SECS_LAST) begin
      n[`RTC_SECS_MSB:`RTC_SECS_LSB] = t[`RTC_SECS_MSB:`RTC_SECS_LSB] + 6'h01;
    end else begin
      n[`RTC_SECS_MSB:`RTC_SECS_LSB] = 6'h00;
      if (t[`RTC_MINS_MSB:`RTC_MINS_LSB] != `RTC_MINS_LAST) begin
        n[`RTC_MINS_MSB:`RTC_MINS_LSB] = t[`RTC_MINS_MSB:`RTC_MINS_LSB] + 6'h01;
      end else begin
        n[`RTC_MINS_MSB:`RTC_MINS_LSB] = 6'h00;
        if (t[`RTC_HOURS_MSB:`RTC_HOURS_LSB] != `RTC_HOURS_LAST) begin
          n[`RTC_HOURS_MSB:`RTC_HOURS_LSB] = t[`RTC_HOURS_MSB:`RTC_HOURS_LSB] + 5'h01;
        end else begin
          n[`RTC_HOURS_MSB:`RTC_HOURS_LSB] = 5'h00;
          n[`RTC_DAYS_MSB:`RTC_DAYS_LSB] = t[`RTC_DAYS_MSB:`RTC_DAYS_LSB] + 11'h001;
        end
      end
    end
    next_time = n;
  endfunction

  // reset release through two flops; assertion is still immediate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // a write lands only on the edge that completes the access phase
  assign wr_en = psel & penable & pwrite & pready_reg;
  assign flag_clr = (wr_en && paddr == `RTC_ADDR_FLAGS) ? pwdata[4:0] : 5'h00;

  // read decode; unknown addresses answer with an error
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h00000000;
    case (paddr)
      `RTC_ADDR_XFAIL: begin
        rd_data[`RTC_XF_UPPER_LSB +: 5] = xf_upper_reg;
        rd_data[`RTC_XF_LOWER_LSB +: 5] = xf_lower_reg;
        rd_data[`RTC_XF_IRQ_BIT] = xf_irq_en_reg;
        rd_data[`RTC_XF_MON_BIT] = xf_mon_en_reg;
      end
      `RTC_ADDR_CTRL: begin
        rd_data[`RTC_CTRL_BIAS_LSB +: 3] = bias_reg;
        rd_data[`RTC_CTRL_OUTLOAD_LSB +: 5] = out_load_reg;
        rd_data[`RTC_CTRL_INLOAD_LSB +: 5] = in_load_reg;
        rd_data[`RTC_CTRL_MODE_LSB +: 2] = osc_mode_reg;
        rd_data[`RTC_CTRL_PRESET_BIT] = ctrl_preset_en_reg;
      end
      `RTC_ADDR_COUNT: rd_data[27:0] = count_reg;
      `RTC_ADDR_PRESET: rd_data[27:0] = preset_reg;
      `RTC_ADDR_INTEN: rd_data[3:0] = int_en_reg;
      `RTC_ADDR_FLAGS: rd_data[4:0] = flags_reg;
      `RTC_ADDR_PRESCALE: rd_data[9:0] = prescale_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // one wait state: pready is a flop, raised in the first access cycle
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~rd_hit;
      prdata_reg <= (psel & penable & ~pready_reg & ~pwrite) ? rd_data : 32'h00000000;
    end
  end

  // control word, analog trim fields kept raw for readback
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_preset_en_reg <= 1'b0;
      osc_mode_reg <= `RTC_MODE_RST;
      in_load_reg <= `RTC_LOAD_RST;
      out_load_reg <= `RTC_LOAD_RST;
      bias_reg <= `RTC_BIAS_RST;
    end else if (wr_en && paddr == `RTC_ADDR_CTRL) begin
      ctrl_preset_en_reg <= pwdata[`RTC_CTRL_PRESET_BIT];
      osc_mode_reg <= pwdata[`RTC_CTRL_MODE_LSB +: 2];
      in_load_reg <= pwdata[`RTC_CTRL_INLOAD_LSB +: 5];
      out_load_reg <= pwdata[`RTC_CTRL_OUTLOAD_LSB +: 5];
      bias_reg <= pwdata[`RTC_CTRL_BIAS_LSB +: 3];
    end
  end

  // analog side sees the effective setting, saturated codes folded
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_out_reg <= `RTC_MODE_RST;
      in_load_out_reg <= `RTC_LOAD_RST;
      out_load_out_reg <= `RTC_LOAD_RST;
      bias_out_reg <= `RTC_BIAS_RST;
    end else begin
      mode_out_reg <= osc_mode_reg;
      in_load_out_reg <= (in_load_reg > `RTC_LOAD_MAX) ? `RTC_LOAD_MAX : in_load_reg;
      out_load_out_reg <= (out_load_reg > `RTC_LOAD_MAX) ? `RTC_LOAD_MAX : out_load_reg;
      bias_out_reg <= (bias_reg > `RTC_BIAS_MIN) ? `RTC_BIAS_MIN : bias_reg;
    end
  end

  // plain software registers
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      preset_reg <= 28'h0000000;
      int_en_reg <= 4'h0;
      prescale_reg <= `RTC_PRESCALE_RST;
      xf_upper_reg <= `RTC_XF_UPPER_RST;
      xf_lower_reg <= `RTC_XF_LOWER_RST;
      xf_irq_en_reg <= 1'b0;
      xf_mon_en_reg <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `RTC_ADDR_PRESET) preset_reg <= pwdata[27:0];
      if (paddr == `RTC_ADDR_INTEN) int_en_reg <= pwdata[3:0];
      if (paddr == `RTC_ADDR_PRESCALE) prescale_reg <= pwdata[9:0];
      if (paddr == `RTC_ADDR_XFAIL) begin
        xf_upper_reg <= pwdata[`RTC_XF_UPPER_LSB +: 5];
        xf_lower_reg <= pwdata[`RTC_XF_LOWER_LSB +: 5];
        xf_irq_en_reg <= pwdata[`RTC_XF_IRQ_BIT];
        xf_mon_en_reg <= pwdata[`RTC_XF_MON_BIT];
      end
    end
  end

  // reference pin is synchronous; a disabled oscillator gives no edges
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_d_reg <= 1'b0;
    end else begin
      ref_d_reg <= crystal_input_pin;
    end
  end
  assign ref_edge = crystal_input_pin & ~ref_d_reg & (osc_mode_reg != `RTC_MODE_OFF);

  // one-second prescaler; >= keeps a lowered trim from overrunning
  assign rollover = sec_rollover(prescale_reg);
  assign tick = ref_edge & ~ctrl_preset_en_reg & (presc_cnt_reg >= rollover - 32'h1);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      presc_cnt_reg <= 32'h00000000;
    end else if (ctrl_preset_en_reg || tick) begin
      presc_cnt_reg <= 32'h00000000;
    end else if (ref_edge) begin
      presc_cnt_reg <= presc_cnt_reg + 32'h1;
    end
  end

  // time counter; preset enable holds it at the preset word
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_reg <= 28'h0000000;
    end else if (ctrl_preset_en_reg) begin
      count_reg <= preset_reg;
    end else if (tick) begin
      count_reg <= next_time(count_reg);
    end
  end

  // interval flags keyed to the new seconds value
  assign count_next = next_time(count_reg);
  assign new_secs = count_next[`RTC_SECS_MSB:`RTC_SECS_LSB];
  always_comb begin
    flag_set = 5'h00;
    flag_set[0] = tick;
    flag_set[1] = tick && (new_secs % `RTC_TEN == 6'h00);
    flag_set[2] = tick && (new_secs % `RTC_THIRTY == 6'h00);
    flag_set[`RTC_FLAG_MIN] = tick && (new_secs == 6'h00);
    flag_set[`RTC_FLAG_FAIL] = fail_event;
  end

  // masks as they stand after this edge, so a lowered enable drops irq at once
  assign int_en_next = (wr_en && paddr == `RTC_ADDR_INTEN) ? pwdata[3:0] : int_en_reg;
  assign xf_irq_en_next = (wr_en && paddr == `RTC_ADDR_XFAIL) ?
    pwdata[`RTC_XF_IRQ_BIT] : xf_irq_en_reg;
  // sticky flags, write one to clear, a new event beats the clear
  assign flags_next = (flags_reg & ~flag_clr) | flag_set;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flags_reg <= 5'h00;
      irq_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      irq_reg <= |(flags_next & {xf_irq_en_next, int_en_next});
    end
  end

  // crystal period counter; every third edge clears the main count
  assign fd_clear = ref_edge & xf_mon_en_reg & (xcnt_reg == `RTC_XF_LAST_PERIOD);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      xcnt_reg <= 2'h0;
    end else if (!xf_mon_en_reg || fd_clear) begin
      xcnt_reg <= 2'h0;
    end else if (ref_edge) begin
      xcnt_reg <= xcnt_reg + 2'h1;
    end
  end

  // main-clock counter saturates so a dead crystal cannot wrap it low
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mcnt_reg <= 6'h00;
    end else if (fd_clear || !xf_mon_en_reg) begin
      mcnt_reg <= 6'h00;
    end else if (mcnt_reg != `RTC_MCNT_MAX) begin
      mcnt_reg <= mcnt_reg + 6'h01;
    end
  end

  // first window after enable is partial, so it is not judged
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fd_state_reg <= RTC_FD_IDLE;
    end else begin
      case (fd_state_reg)
        RTC_FD_IDLE: if (xf_mon_en_reg) fd_state_reg <= RTC_FD_ARM;
        RTC_FD_ARM: begin
          if (!xf_mon_en_reg) fd_state_reg <= RTC_FD_IDLE;
          else if (fd_clear) fd_state_reg <= RTC_FD_RUN;
        end
        RTC_FD_RUN: if (!xf_mon_en_reg) fd_state_reg <= RTC_FD_IDLE;
        default: fd_state_reg <= RTC_FD_IDLE;
      endcase
    end
  end
  assign fail_event = fd_clear && (fd_state_reg == RTC_FD_RUN) &&
    ((mcnt_reg > {1'b0, xf_upper_reg}) || (mcnt_reg < {1'b0, xf_lower_reg}));

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign oscillator_input_mode = mode_out_reg;
  assign input_pin_load_code = in_load_out_reg;
  assign output_pin_load_code = out_load_out_reg;
  assign bias_select = bias_out_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  property p_count_hold;
    !tick && !ctrl_preset_en_reg |=> $stable(count_reg);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("time count moved without tick");
  property p_preset_load;
    ctrl_preset_en_reg |=> count_reg == $past(preset_reg);
  endproperty
  a_preset_load: assert property (p_preset_load) else $error("preset not loaded");
  property p_sec_wrap;
    tick && count_reg[5:0] == `RTC_SECS_LAST |=> count_reg[5:0] == 6'h00 && flags_reg[3];
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");
  property p_sec_flag;
    tick |=> flags_reg[0] ##0 (irq || !int_en_reg[0]);
  endproperty
  a_sec_flag: assert property (p_sec_flag) else $error("second flag or irq missing");
  property p_presc_restart;
    tick |=> presc_cnt_reg == 32'h00000000 ##1 presc_cnt_reg <= 32'h00000001;
  endproperty
  a_presc_restart: assert property (p_presc_restart) else $error("prescaler not restarted");
  property p_clear_period;
    fd_clear |=> xcnt_reg == 2'h0 && mcnt_reg == 6'h00;
  endproperty
  a_clear_period: assert property (p_clear_period) else $error("clear did not restart");
  property p_upper_fail;
    fd_clear && fd_state_reg == RTC_FD_RUN && mcnt_reg > {1'b0, xf_upper_reg} |=> flags_reg[4];
  endproperty
  a_upper_fail: assert property (p_upper_fail) else $error("upper limit miss");
  property p_lower_fail;
    fd_clear && fd_state_reg == RTC_FD_RUN && mcnt_reg < {1'b0, xf_lower_reg} |=> flags_reg[4];
  endproperty
  a_lower_fail: assert property (p_lower_fail) else $error("lower limit miss");
  property p_mon_off;
    !xf_mon_en_reg |=> !$rose(flags_reg[4]);
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("fail flag while monitor off");
  property p_irq_gate;
    irq == |(flags_reg & {xf_irq_en_reg, int_en_reg});
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enabled flag");

endmodule
`default_nettype wire

// File: tb/rtc_xtal_model.sv
`timescale 1ns/1ps
`default_nettype none

// stand-in for the crystal or external reference on the clock input pin
module rtc_xtal_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] half_cycles,
  output logic pin
);
  logic [7:0] cnt;

  // idle low from time zero so the pin is never unknown
  initial begin
    cnt = 8'h00;
    pin = 1'b0;
  end

  // toggles every half_cycles clocks; a larger count is a slow source
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 8'h00;
      pin <= 1'b0;
    end else if (cnt + 8'h01 >= half_cycles) begin
      cnt <= 8'h00;
      pin <= ~pin;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"

module tb_top;
  localparam int BASE = 20;
  localparam logic [31:0] RUN = 32'h00023CF0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, xin, irq;
  logic [1:0] mode;
  logic [4:0] inl, outl;
  logic [2:0] bias;
  logic [7:0] half = 8'h02;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  logic [64:0] exp_q [$];
  logic [64:0] note;
  logic [31:0] v;
  logic [10:0] d;
  logic [9:0] p;
  logic [31:0] raddr [7] = '{`RTC_ADDR_XFAIL, `RTC_ADDR_CTRL, `RTC_ADDR_COUNT,
    `RTC_ADDR_PRESET, `RTC_ADDR_INTEN, `RTC_ADDR_FLAGS, `RTC_ADDR_PRESCALE};
  logic [31:0] rval [7] = '{32'h828, 32'h23CFC, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2CF};
  logic [31:0] pre [4];
  logic [31:0] nxt [4];
  logic [3:0] flg [4] = '{4'h3, 4'h7, 4'hF, 4'hF};
  int hc [8] = '{2, 5, 1, 3, 3, 2, 5, 5};
  logic [11:0] xv [8] = '{12'h82B, 12'h82B, 12'h82B, 12'h82B, 12'hA2B, 12'h83B, 12'h829,
    12'h82A};
  logic [7:0] flv = 8'h6E;

  rtc_top #(.ONE_SEC_BASE(BASE)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_input_pin(xin), .irq(irq),
    .oscillator_input_mode(mode), .input_pin_load_code(inl), .output_pin_load_code(outl),
    .bias_select(bias));

  rtc_xtal_model xtal_u (.clk(clk), .run(1'b1), .half_cycles(half), .pin(xin));

  // 100 MHz clock and a free cycle count for interval timing
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one transfer; the expected answer is noted before the request goes out
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] dat,
                     input logic err, input logic [31:0] m, input logic [31:0] e);
    int n;
    exp_q.push_back({err, m, e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat, 1'b0, 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    apb(1'b0, a, 32'h0, 1'b0, m, e);
  endtask

  // bounded wait; a stuck level counts as a mismatch
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) fail_count++;
  endtask

  // clear the seconds flag first, else the old level would end the wait at once
  task automatic next_sec();
    wr(`RTC_ADDR_FLAGS, 32'h1);
    wait_irq(1'b0);
    wait_irq(1'b1);
  endtask

  function automatic logic [4:0] lim(input logic [4:0] x, input logic [4:0] top);
    return (x > top) ? top : x;
  endfunction

  function automatic logic [31:0] tw(input logic [10:0] dd, input logic [4:0] h,
                                     input logic [5:0] m, input logic [5:0] s);
    return {4'h0, dd, h, m, s};
  endfunction

  // scoreboard: every answer takes the oldest note off the queue
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(33'h1, 33'h0);
      end else begin
        note = exp_q.pop_front();
        check({pslverr, prdata & note[63:32]}, {note[64], note[31:0] & note[63:32]});
      end
    end
  end

  // watchdog well beyond the expected few thousand cycles
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    void'($urandom(32'hA71E));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check({26'h0, mode, 5'(bias)}, {26'h0, 2'h3, 5'h04});
    check({23'h0, inl, outl}, {23'h0, 5'h0F, 5'h0F});
    // reference runs, but the disabled mode must keep the count at zero
    repeat (500) @(posedge clk);
    foreach (raddr[i]) rd(raddr[i], rval[i]);
    apb(1'b0, 32'hFFF7E418, 32'h0, 1'b1, '1, 32'h0);
    apb(1'b1, 32'hFFF7E418, 32'hFFFFFFFF, 1'b1, 32'h0, 32'h0);
    // every input mode code, random load and bias codes incl. over-range ones
    for (int i = 0; i < 4; i++) begin
      v = ($urandom() & 32'hFFFFFFF2) | (32'(i) << 2);
      wr(`RTC_ADDR_CTRL, v);
      rd(`RTC_ADDR_CTRL, v & 32'h0003FDFD);
      check({26'h0, mode, 5'(bias)}, {26'h0, v[3:2], lim(5'(v[17:15]), 5'h04)});
      check({23'h0, inl, outl}, {23'h0, lim(v[8:4], 5'h14), lim(v[14:10], 5'h14)});
    end
    wr(`RTC_ADDR_CTRL, RUN);
    wr(`RTC_ADDR_INTEN, 32'h1);
    d = 11'($urandom());
    pre = '{tw(d, 5'h03, 6'h0A, 6'h09), tw(d, 5'h00, 6'h3B, 6'h1D),
      tw(d, 5'h16, 6'h3B, 6'h3B), tw(11'h7FF, 5'h17, 6'h3B, 6'h3B)};
    nxt = '{tw(d, 5'h03, 6'h0A, 6'h0A), tw(d, 5'h00, 6'h3B, 6'h1E),
      tw(d, 5'h17, 6'h00, 6'h00), 32'h0};
    // load each boundary, then one second later check count and interval flags
    for (int i = 0; i < 4; i++) begin
      wr(`RTC_ADDR_PRESET, pre[i]);
      wr(`RTC_ADDR_CTRL, RUN | 32'h1);
      wr(`RTC_ADDR_COUNT, 32'hFFFFFFFF);
      rd(`RTC_ADDR_COUNT, pre[i]);
      wr(`RTC_ADDR_FLAGS, 32'h1F);
      wr(`RTC_ADDR_CTRL, RUN);
      wait_irq(1'b0);
      wait_irq(1'b1);
      rd(`RTC_ADDR_FLAGS, 32'(flg[i]), 32'hF);
      rd(`RTC_ADDR_COUNT, nxt[i]);
    end
    // all four flags stand: clearing only the enabled one must drop irq
    wr(`RTC_ADDR_FLAGS, 32'h1);
    repeat (2) @(posedge clk);
    check({32'h0, irq}, 33'h0);
    wr(`RTC_ADDR_INTEN, 32'h8);
    repeat (2) @(posedge clk);
    check({32'h0, irq}, 33'h1);
    rd(`RTC_ADDR_FLAGS, 32'hE, 32'hE);
    wr(`RTC_ADDR_INTEN, 32'h1);
    repeat (2) @(posedge clk);
    check({32'h0, irq}, 33'h0);
    // one step either side of nominal moves the second by eight reference periods
    for (int i = 0; i < 3; i++) begin
      p = 10'h2CE + 10'(i);
      wr(`RTC_ADDR_PRESCALE, 32'(p));
      rd(`RTC_ADDR_PRESCALE, 32'(p));
      next_sec();
      next_sec();
      t0 = cyc;
      next_sec();
      check(33'(cyc - t0), 33'(4 * (BASE + (int'(p) - 'h2CF) * 8)));
    end
    wr(`RTC_ADDR_INTEN, 32'h0);
    // nominal, slow, fast and moved limits; then irq gated off and monitor off
    for (int i = 0; i < 8; i++) begin
      half <= 8'(hc[i]);
      wr(`RTC_ADDR_XFAIL, 32'(xv[i]));
      rd(`RTC_ADDR_XFAIL, 32'(xv[i]));
      repeat (150) @(posedge clk);
      wr(`RTC_ADDR_FLAGS, 32'h10);
      repeat (150) @(posedge clk);
      check({32'h0, irq}, {32'h0, flv[i] & xv[i][1]});
      rd(`RTC_ADDR_FLAGS, {27'h0, flv[i], 4'h0}, 32'h10);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
